// >>> hdl/stmr_defs.svh
`ifndef STMR_DEFS_SVH
`define STMR_DEFS_SVH
// ----------------------------------------------------------------
// register offsets (host address, demultiplexed numbering)
// ----------------------------------------------------------------
`define STMR_OFS_XFER_A_TX     4'h7
`define STMR_OFS_XFER_B_TX     4'h8
`define STMR_OFS_XFER_CTRL     4'h9
`define STMR_OFS_MON_CHAN      4'hA
`define STMR_OFS_MON_FIFO      4'hB
`define STMR_OFS_SIG_TIMER     4'hC
// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define STMR_CTRL_A_EN_BIT     7
`define STMR_CTRL_B_EN_BIT     6
`define STMR_CTRL_TYPE_B_LSB   3
`define STMR_CTRL_TYPE_A_LSB   0
`define STMR_CTRL_RST          8'h00
`define STMR_TIMER_SETUP_RST          8'h00
`define STMR_TYPE_FULL         3'h1
`define STMR_MF_TIMER          3'h7
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define STMR_CLK_NS            8
`define STMR_TICK_NS           250000
`define STMR_LOOK_NS           125000
`define STMR_MON_DEPTH         16
`define STMR_SIG_DEPTH         9
`endif

// >>> hdl/stmr_pkg.sv
package stmr_pkg;
  // transmit address of one transfer channel
  typedef struct packed {
    logic       iface_sel;
    logic [6:0] slot;
  } stmr_addr_s;
  // enable and type of one transfer channel
  typedef struct packed {
    logic       enable;
    logic [2:0] ctype;
  } stmr_chan_s;
  typedef enum logic {TMR_IDLE, TMR_RUN} stmr_tmr_e;
endpackage

// >>> hdl/stmr_regs.sv
`timescale 1ns/100ps
`include "stmr_defs.svh"
// Function
// - channel A output select: 0 routes data to PCM, 1 to subscriber line
// - channel B output select: 0 routes data to PCM, 1 to subscriber line
// - seven slot bits per channel, coded like memory-access address bits
// - per-channel enable bit: 1 runs the transfer, 0 stops it
// - 3-bit type picks bandwidth and bit position; 000 invalid; here it masks only the PCM byte, the subscriber byte goes whole
// - search-active bit reads 1 while search runs, 0 when done
// - found-channel address gives slot of detected active monitor channel
// - two transfer-control bits join command bits to pick monitor mode
// - subscriber address drops direction and even/odd bit of CM address
// - monitor FIFO holds 16 bytes in either direction
// - monitor bytes leave on subscriber line MSB first
// - signaling FIFO nine entries deep of changed slot addresses
// - entry bit 7 is valid flag; whole entry usable as access address
// - entry address even for command change, odd for signaling change
// - timer gives periodic tick, multiframe pulse, last-look period
// - rate bit 0: last look from timer value; 1: fixed 125 us
// - timer period is (1 + value) times 250 us
// - start on start command; stop on timer write or main bit low
// - access address bit 7 is direction, bits 6..0 port and slot
// - timer counts cyclically 0 up to programmed value then wraps

// ----------------------------------------------------------------
// generic first-in first-out buffer
// ----------------------------------------------------------------
module stmr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic                       ref_clk_in,
  input  wire logic                       sys_rst_in,
  input  wire logic                       flush_in,
  input  wire logic                       in_valid_in,
  output      logic                       in_ready_out,
  input  wire logic [WIDTH-1:0]           in_data_in,
  output      logic                       out_valid_out,
  input  wire logic                       out_ready_in,
  output      logic [WIDTH-1:0]           out_data_out,
  output      logic [$clog2(DEPTH+1)-1:0] count_out
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0]           mem_r [DEPTH];
  logic [PW-1:0]              wr_ptr_r;
  logic [PW-1:0]              rd_ptr_r;
  logic [$clog2(DEPTH+1)-1:0] cnt_r;
  wire                        push = in_valid_in & in_ready_out;
  wire                        pop  = out_valid_out & out_ready_in;

  // full and empty straight from the fill count
  assign in_ready_out  = (cnt_r != DEPTH[$clog2(DEPTH+1)-1:0]);
  assign out_valid_out = (cnt_r != '0);
  assign out_data_out  = mem_r[rd_ptr_r];
  assign count_out     = cnt_r;

  // pointers wrap at DEPTH so odd depths work too
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || flush_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == PW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == PW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      end
      cnt_r <= cnt_r + push - pop;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_in;
    end
  end
endmodule

// ----------------------------------------------------------------
// transfer, monitor and timer register bank
// ----------------------------------------------------------------
module stmr_regs import stmr_pkg::*; #(
  parameter int TICK_CYC = `STMR_TICK_NS / `STMR_CLK_NS,
  parameter int LOOK_CYC = `STMR_LOOK_NS / `STMR_CLK_NS,
  parameter int MON_DEPTH = `STMR_MON_DEPTH,
  parameter int SIG_DEPTH = `STMR_SIG_DEPTH
) (
  input  wire logic            ref_clk_in,
  input  wire logic            sys_rst_in,
  input  wire logic            mux_mode_in,
  input  wire logic            register_bank_sel_in,
  input  wire logic [4:0]      addr_in,
  input  wire logic            cs_in,
  input  wire logic            rd_in,
  input  wire logic            wr_in,
  input  wire logic [7:0]      wr_data_in,
  output      logic [7:0]      rd_data_out,
  input  wire logic [1:0][7:0] chan_data_reg_in,
  input  wire logic [1:0]      chan_slot_tick_in,
  output      stmr_addr_s [1:0] chan_addr_out,
  output      stmr_chan_s [1:0] chan_cfg_out,
  output      logic [1:0][7:0] pcm_data_out,
  output      logic [1:0][7:0] pcm_mask_out,
  output      logic [1:0]      pcm_strobe_out,
  output      logic [1:0][7:0] sub_data_out,
  output      logic [1:0]      sub_strobe_out,
  input  wire logic            search_start_in,
  input  wire logic            chan_found_in,
  input  wire logic [5:0]      chan_found_addr_in,
  output      logic            search_active_out,
  output      logic [1:0]      monitor_xfer_ctrl_out,
  output      logic [5:0]      subscriber_slot_addr_out,
  output      logic [6:0]      subscriber_cm_addr_out,
  input  wire logic            mon_rx_dir_in,
  input  wire logic            mon_fifo_reset_in,
  input  wire logic            mon_bit_tick_in,
  output      logic            monitor_bit_out,
  output      logic            monitor_bit_valid_out,
  input  wire logic            mon_rx_valid_in,
  input  wire logic [7:0]      mon_rx_byte_in,
  output      logic            mon_rx_ready_out,
  input  wire logic            sig_change_valid_in,
  input  wire logic [6:0]      changed_slot_addr_in,
  output      logic            sig_change_ready_out,
  input  wire logic            sig_fifo_reset_in,
  input  wire logic            timer_start_cmd_in,
  input  wire logic            main_operating_bit_in,
  input  wire logic [2:0]      multiframe_ctrl_field_in,
  output      logic            timer_active_out,
  output      logic            timer_expire_out,
  output      logic            multiframe_pulse_out,
  output      logic            last_look_pulse_out
);
  // ----------------------------------------------------------------
  // bit-position mask of a channel type
  // ----------------------------------------------------------------
  function automatic logic [7:0] type_mask(input logic [2:0] t);
    case (t)
      3'h1:    type_mask = 8'hFF;
      3'h2:    type_mask = 8'h0F;
      3'h3:    type_mask = 8'hF0;
      3'h4:    type_mask = 8'h03;
      3'h5:    type_mask = 8'h0C;
      3'h6:    type_mask = 8'h30;
      3'h7:    type_mask = 8'hC0;
      default: type_mask = 8'h00; // invalid code clears every PCM bit; the subscriber byte is not masked
    endcase
  endfunction

  // ----------------------------------------------------------------
  // address decode; multiplexed mode doubles the address
  // ----------------------------------------------------------------
  wire [3:0] reg_addr = mux_mode_in ? addr_in[4:1] : addr_in[3:0];
  wire       sel      = cs_in & ~register_bank_sel_in;
  wire       wr_hit   = sel & wr_in;
  wire       rd_hit   = sel & rd_in;
  wire       wr_a     = wr_hit & (reg_addr == `STMR_OFS_XFER_A_TX);
  wire       wr_b     = wr_hit & (reg_addr == `STMR_OFS_XFER_B_TX);
  wire       wr_ctrl  = wr_hit & (reg_addr == `STMR_OFS_XFER_CTRL);
  wire       wr_sub   = wr_hit & (reg_addr == `STMR_OFS_MON_CHAN);
  wire       wr_mon   = wr_hit & (reg_addr == `STMR_OFS_MON_FIFO);
  wire       wr_timer_setup  = wr_hit & (reg_addr == `STMR_OFS_SIG_TIMER);
  wire       rd_mon   = rd_hit & (reg_addr == `STMR_OFS_MON_FIFO);
  wire       rd_sig   = rd_hit & (reg_addr == `STMR_OFS_SIG_TIMER);

  // ----------------------------------------------------------------
  // host-written registers
  // ----------------------------------------------------------------
  stmr_addr_s [1:0] tx_addr_r;
  logic [7:0]       ctrl_r;
  logic [7:0]       sub_r;
  logic [7:0]       timer_setup_r;
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      tx_addr_r <= '0;
      ctrl_r    <= `STMR_CTRL_RST;
      sub_r     <= 8'h00;
      timer_setup_r    <= `STMR_TIMER_SETUP_RST;
    end else begin
      if (wr_a)    tx_addr_r[0] <= wr_data_in;
      if (wr_b)    tx_addr_r[1] <= wr_data_in;
      if (wr_ctrl) ctrl_r       <= wr_data_in;
      if (wr_sub)  sub_r        <= wr_data_in;
      if (wr_timer_setup) timer_setup_r       <= wr_data_in;
    end
  end

  // ----------------------------------------------------------------
  // transfer channels: masked byte to PCM, whole byte to subscriber line, by the output select
  // ----------------------------------------------------------------
  stmr_chan_s [1:0] cfg;
  assign cfg[0] = {ctrl_r[`STMR_CTRL_A_EN_BIT],
                   ctrl_r[`STMR_CTRL_TYPE_A_LSB +: 3]};
  assign cfg[1] = {ctrl_r[`STMR_CTRL_B_EN_BIT],
                   ctrl_r[`STMR_CTRL_TYPE_B_LSB +: 3]};
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_chan
      wire go  = chan_slot_tick_in[gi] & cfg[gi].enable;
      wire sub = tx_addr_r[gi].iface_sel;
      always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
          pcm_strobe_out[gi] <= 1'b0;
          sub_strobe_out[gi] <= 1'b0;
          pcm_data_out[gi]   <= 8'h00;
          pcm_mask_out[gi]   <= 8'h00;
          sub_data_out[gi]   <= 8'h00;
        end else begin
          pcm_strobe_out[gi] <= go & ~sub;
          sub_strobe_out[gi] <= go & sub;
          pcm_mask_out[gi]   <= type_mask(cfg[gi].ctype);
          pcm_data_out[gi]   <= chan_data_reg_in[gi]
                                & type_mask(cfg[gi].ctype);
          sub_data_out[gi]   <= chan_data_reg_in[gi];
        end
      end
    end
  endgenerate
  always_ff @(posedge ref_clk_in) begin
    chan_addr_out <= sys_rst_in ? '0 : tx_addr_r;
    chan_cfg_out  <= sys_rst_in ? '0 : cfg;
  end

  // ----------------------------------------------------------------
  // channel search and subscriber address
  // ----------------------------------------------------------------
  logic       search_r;
  logic [5:0] found_r;
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      search_r <= 1'b0;
      found_r  <= 6'h00;
    end else begin
      // a new start wins over a stop in the same cycle
      if (search_start_in) search_r <= 1'b1;
      else if (chan_found_in || !main_operating_bit_in) search_r <= 1'b0;
      if (chan_found_in) found_r <= chan_found_addr_in;
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      search_active_out        <= 1'b0;
      monitor_xfer_ctrl_out    <= 2'h0;
      subscriber_slot_addr_out <= 6'h00;
      subscriber_cm_addr_out   <= 7'h00;
    end else begin
      search_active_out        <= search_r;
      monitor_xfer_ctrl_out    <= sub_r[7:6];
      subscriber_slot_addr_out <= sub_r[5:0];
      subscriber_cm_addr_out   <= {sub_r[5:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // monitor FIFO: host fills it for transmit, line fills it for receive
  // ----------------------------------------------------------------
  localparam int MCW = $clog2(MON_DEPTH+1);
  logic           mon_out_valid;
  logic [7:0]     mon_out_data;
  logic [MCW-1:0] mon_count;
  logic [7:0]     shift_r;
  logic [3:0]     bits_left_r;
  wire  load       = ~mon_rx_dir_in & (bits_left_r == 4'h0) & mon_out_valid;
  wire  mon_in_vld = mon_rx_dir_in ? mon_rx_valid_in : wr_mon;
  wire  [7:0] mon_in_dat = mon_rx_dir_in ? mon_rx_byte_in : wr_data_in;
  wire  mon_pop    = mon_rx_dir_in ? rd_mon : load;
  stmr_fifo #(.WIDTH(8), .DEPTH(MON_DEPTH)) u_mon_fifo (
    .ref_clk_in    (ref_clk_in),
    .sys_rst_in    (sys_rst_in),
    .flush_in      (mon_fifo_reset_in),
    .in_valid_in   (mon_in_vld),
    .in_ready_out  (),
    .in_data_in    (mon_in_dat),
    .out_valid_out (mon_out_valid),
    .out_ready_in  (mon_pop),
    .out_data_out  (mon_out_data),
    .count_out     (mon_count)
  );

  // serializer: one bit per tick, most significant bit first
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || mon_fifo_reset_in) begin
      shift_r               <= 8'h00;
      bits_left_r           <= 4'h0;
      monitor_bit_out       <= 1'b0;
      monitor_bit_valid_out <= 1'b0;
    end else begin
      monitor_bit_valid_out <= 1'b0;
      if (load) begin
        shift_r     <= mon_out_data;
        bits_left_r <= 4'h8;
      end else if (mon_bit_tick_in && bits_left_r != 4'h0) begin
        monitor_bit_out       <= shift_r[7];
        monitor_bit_valid_out <= 1'b1;
        shift_r               <= {shift_r[6:0], 1'b0};
        bits_left_r           <= bits_left_r - 4'h1;
      end
    end
  end

  // ready lags a cycle, so it drops one slot before full
  always_ff @(posedge ref_clk_in) begin
    mon_rx_ready_out <= ~sys_rst_in & mon_rx_dir_in & ~mon_fifo_reset_in
                        & (mon_count < MCW'(MON_DEPTH-1));
  end

  // ----------------------------------------------------------------
  // signaling change FIFO
  // ----------------------------------------------------------------
  localparam int SCW = $clog2(SIG_DEPTH+1);
  logic           sig_valid;
  logic [6:0]     sig_data;
  logic [SCW-1:0] sig_count;
  stmr_fifo #(.WIDTH(7), .DEPTH(SIG_DEPTH)) u_sig_fifo (
    .ref_clk_in    (ref_clk_in),
    .sys_rst_in    (sys_rst_in),
    .flush_in      (sig_fifo_reset_in),
    .in_valid_in   (sig_change_valid_in),
    .in_ready_out  (),
    .in_data_in    (changed_slot_addr_in),
    .out_valid_out (sig_valid),
    .out_ready_in  (rd_sig),
    .out_data_out  (sig_data),
    .count_out     (sig_count)
  );
  always_ff @(posedge ref_clk_in) begin
    sig_change_ready_out <= ~sys_rst_in & ~sig_fifo_reset_in
                            & (sig_count < SCW'(SIG_DEPTH-1));
  end

  // ----------------------------------------------------------------
  // read data; shared addresses return the read-only side
  // ----------------------------------------------------------------
  logic [7:0] rd_nxt;
  always_comb begin
    case (reg_addr)
      `STMR_OFS_XFER_A_TX:  rd_nxt = tx_addr_r[0];
      `STMR_OFS_XFER_B_TX:  rd_nxt = tx_addr_r[1];
      `STMR_OFS_XFER_CTRL:  rd_nxt = ctrl_r;
      `STMR_OFS_MON_CHAN:   rd_nxt = {1'b0, search_r, found_r};
      `STMR_OFS_MON_FIFO:   rd_nxt = mon_out_valid ? mon_out_data : 8'h00;
      `STMR_OFS_SIG_TIMER:  rd_nxt = sig_valid ? {1'b1, sig_data}
                                               : 8'h00;
      default:              rd_nxt = 8'h00;
    endcase
  end
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) rd_data_out <= 8'h00;
    else if (rd_hit) rd_data_out <= rd_nxt;
  end

  // ----------------------------------------------------------------
  // timer: prescaler of 250 us steps, value counter wraps at setting
  // ----------------------------------------------------------------
  stmr_tmr_e   tmr_r;
  logic [31:0] pre_r;
  logic [6:0]  val_r;
  logic [31:0] look_r;
  wire pre_end  = (pre_r == 32'(TICK_CYC - 1));
  wire val_end  = (val_r == timer_setup_r[6:0]);
  wire expire   = (tmr_r == TMR_RUN) & pre_end & val_end;
  wire look_end = (look_r == 32'(LOOK_CYC - 1));
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      tmr_r <= TMR_IDLE;
      pre_r <= '0;
      val_r <= '0;
    end else begin
      case (tmr_r)
        TMR_IDLE: begin
          pre_r <= '0;
          val_r <= '0;
          if (timer_start_cmd_in && main_operating_bit_in) begin
            tmr_r <= TMR_RUN;
          end
        end
        TMR_RUN: begin
          pre_r <= pre_end ? '0 : pre_r + 32'h1;
          if (pre_end) val_r <= val_end ? 7'h00 : val_r + 7'h01;
          // a start in the cycle of the stop restarts from zero
          if (timer_start_cmd_in && main_operating_bit_in) begin
            if (wr_timer_setup) begin
              pre_r <= '0;
              val_r <= '0;
            end
          end else if (wr_timer_setup || !main_operating_bit_in) begin
            tmr_r <= TMR_IDLE;
          end
        end
        default: tmr_r <= TMR_IDLE;
      endcase
    end
  end

  // fixed 125 us last-look grid runs while the device operates
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || !main_operating_bit_in || look_end) look_r <= '0;
    else look_r <= look_r + 32'h1;
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      timer_active_out     <= 1'b0;
      timer_expire_out     <= 1'b0;
      multiframe_pulse_out <= 1'b0;
      last_look_pulse_out  <= 1'b0;
    end else begin
      timer_active_out     <= (tmr_r == TMR_RUN);
      timer_expire_out     <= expire;
      multiframe_pulse_out <= expire &
        (multiframe_ctrl_field_in == `STMR_MF_TIMER);
      last_look_pulse_out  <= timer_setup_r[7] ? (look_end & main_operating_bit_in)
                                        : expire;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  a_route_pcm_a: assert property (chan_slot_tick_in[0] & cfg[0].enable
    & ~tx_addr_r[0].iface_sel |=> pcm_strobe_out[0] & ~sub_strobe_out[0])
    else $error("channel A not routed to PCM");
  a_route_sub_b: assert property (chan_slot_tick_in[1] & cfg[1].enable
    & tx_addr_r[1].iface_sel |=> sub_strobe_out[1] & ~pcm_strobe_out[1])
    else $error("channel B not routed to subscriber line");
  a_chan_disabled: assert property (!cfg[0].enable |=>
    !pcm_strobe_out[0] && !sub_strobe_out[0])
    else $error("disabled channel transferred");
  a_type_mask: assert property (ctrl_r[2:0] == 3'h6 |=>
    pcm_mask_out[0] == 8'h30) else $error("wrong bit mask");
  a_search_flag: assert property (search_start_in |=> ##1
    search_active_out) else $error("search flag not raised");
  a_cm_addr_even: assert property (wr_sub |=> ##1
    subscriber_cm_addr_out == {$past(wr_data_in[5:0], 2), 1'b0})
    else $error("subscriber address not even");
  a_sig_entry: assert property (rd_sig |=> rd_data_out[7] ==
    $past(sig_valid)) else $error("valid flag wrong");
  a_msb_first: assert property (load ##1 mon_bit_tick_in |=>
    monitor_bit_out == $past(mon_out_data[7], 2))
    else $error("monitor byte not MSB first");
  a_timer_stop: assert property ((tmr_r == TMR_RUN) & wr_timer_setup
    & ~timer_start_cmd_in |=> ##1 !timer_active_out)
    else $error("timer write did not stop timer");
  a_timer_wrap: assert property (pre_end & val_end & ~wr_timer_setup
    & (tmr_r == TMR_RUN) |=> val_r == 7'h00) else $error("timer no wrap");
  c_sub_xfer:   cover property (sub_strobe_out[0]);
  c_mon_full:   cover property (mon_count == MCW'(MON_DEPTH));
  c_sig_read:   cover property (rd_sig && sig_valid);
  c_mf_pulse:   cover property (multiframe_pulse_out);
endmodule

// >>> bench/stmr_line_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// line-side receiver of the monitor serial bits
// ------------------------------------------------------------
module stmr_line_model (
  input  wire logic       ref_clk_in,
  input  wire logic       run_in,
  input  wire logic       bit_in,
  input  wire logic       bit_valid_in,
  output      logic       tick_out,
  output      logic [7:0] byte_out,
  output      logic [3:0] nbits_out
);
  logic [1:0] div_r;
  // slow line: first bit asked at once, then every fourth cycle
  assign tick_out = run_in && (div_r == 2'h0);
  // first bit on the line ends up in the top of the byte
  always_ff @(posedge ref_clk_in) begin
    div_r <= run_in ? div_r + 2'h1 : 2'h0;
    if (!run_in) begin
      nbits_out <= 4'h0;
    end else if (bit_valid_in) begin
      byte_out <= {byte_out[6:0], bit_in};
      nbits_out <= nbits_out + 4'h1;
    end
  end
endmodule

// >>> bench/switch_transfer_monitor_timer_regs_bench.sv
`timescale 1ns/100ps
module switch_transfer_monitor_timer_regs_bench;
  logic ref_clk_in = 1'b0, sys_rst_in = 1'b1, cs_in = 1'b0, run = 1'b0;
  logic rd_in = 1'b0, wr_in = 1'b0, mux_mode_in = 1'b0, mon_rx_dir_in = 1'b0;
  logic search_start_in = 1'b0, chan_found_in = 1'b0, mon_rx_valid_in = 1'b0;
  logic sig_change_valid_in = 1'b0, timer_start_cmd_in = 1'b0;
  logic main_operating_bit_in = 1'b1, timer_expire_out, timer_active_out;
  logic monitor_bit_out, monitor_bit_valid_out, mon_bit_tick_in;
  logic [1:0] chan_slot_tick_in = 2'h0, pcm_strobe_out, sub_strobe_out;
  logic [1:0] monitor_xfer_ctrl_out;
  logic [2:0] mf = 3'h0;
  logic srch, mf_pulse;
  logic [1:0][7:0] chan_data_reg_in = {8'h3C, 8'hA5}, pcm_data_out;
  logic [1:0][7:0] sub_data_out;
  logic [4:0] addr_in = 5'h00;
  logic [7:0] wr_data_in = 8'h00, mon_rx_byte_in = 8'h00, rd_data_out, seen;
  logic [6:0] changed_slot_addr_in = 7'h00, subscriber_cm_addr_out;
  logic [5:0] chan_found_addr_in = 6'h00;
  logic [3:0] nbits;
  int mismatches = 0, num_checks = 0, cyc = 0, gap;
  // short tick so a timer period spans tens of cycles, not thousands
  stmr_regs #(.TICK_CYC(10), .LOOK_CYC(5)) stmr_regs_inst (.ref_clk_in,
    .sys_rst_in, .mux_mode_in, .register_bank_sel_in(1'b0), .addr_in, .cs_in,
    .rd_in, .wr_in, .wr_data_in, .rd_data_out, .chan_data_reg_in,
    .chan_slot_tick_in, .chan_addr_out(), .chan_cfg_out(), .pcm_data_out,
    .pcm_mask_out(), .pcm_strobe_out, .sub_data_out, .sub_strobe_out,
    .search_start_in, .chan_found_in, .chan_found_addr_in,
    .search_active_out(srch), .monitor_xfer_ctrl_out,
    .subscriber_slot_addr_out(), .subscriber_cm_addr_out, .mon_rx_dir_in,
    .mon_fifo_reset_in(1'b0), .mon_bit_tick_in, .monitor_bit_out,
    .monitor_bit_valid_out, .mon_rx_valid_in, .mon_rx_byte_in,
    .mon_rx_ready_out(), .sig_change_valid_in, .changed_slot_addr_in,
    .sig_change_ready_out(), .sig_fifo_reset_in(1'b0), .timer_start_cmd_in,
    .main_operating_bit_in, .multiframe_ctrl_field_in(mf),
    .timer_active_out, .timer_expire_out, .multiframe_pulse_out(mf_pulse),
    .last_look_pulse_out());
  stmr_line_model stmr_line_model_inst (.ref_clk_in, .run_in(run),
    .bit_in(monitor_bit_out), .bit_valid_in(monitor_bit_valid_out),
    .tick_out(mon_bit_tick_in), .byte_out(seen), .nbits_out(nbits));
  // ------------------------------------------------------------
  // clock, watchdog and host-side tasks
  // ------------------------------------------------------------
  always #4 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      close_out();
    end
  end
  task automatic chk(input string n, input logic [7:0] e, g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // one-cycle strobe; request held until the edge that takes it
  task automatic acc(input logic [4:0] a, input logic w, logic [7:0] d);
    @(posedge ref_clk_in);
    addr_in <= a;
    cs_in <= 1'b1;
    rd_in <= !w;
    wr_in <= w;
    wr_data_in <= d;
    @(posedge ref_clk_in);
    cs_in <= 1'b0;
    rd_in <= 1'b0;
    wr_in <= 1'b0;
    @(posedge ref_clk_in);
    #1;
  endtask
  task automatic rd(input logic [4:0] a, logic [7:0] e, input string n);
    acc(a, 1'b0, 8'h00);
    chk(n, e, rd_data_out);
  endtask
  task automatic edges(input int k);
    repeat (k) @(posedge ref_clk_in);
    #1;
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    edges(8);
    sys_rst_in <= 1'b0;
    rd(5'h09, 8'h00, "ctrl reset");
    rd(5'h0C, 8'h00, "empty signal fifo");
    rd(5'h03, 8'h00, "unmapped");
    acc(5'h07, 1'b1, 8'h85);
    acc(5'h08, 1'b1, 8'h12);
    rd(5'h07, 8'h85, "chan a addr");
    mux_mode_in <= 1'b1;
    rd(5'h10, 8'h12, "chan b addr mux");
    mux_mode_in <= 1'b0;
    acc(5'h09, 1'b1, 8'h89);
    chan_slot_tick_in <= 2'h3;
    edges(1);
    chan_slot_tick_in <= 2'h0;
    // strobes last one cycle: look at once
    chk("strobes a only", 8'h01, {pcm_strobe_out, sub_strobe_out});
    chk("sub data a", 8'hA5, sub_data_out[0]);
    $display("test channels a ended");
    // every bandwidth code on channel b, which goes to pcm
    for (int t = 1; t < 8; t++) begin
      acc(5'h09, 1'b1, {2'b11, t[2:0], t[2:0]});
      chan_slot_tick_in <= 2'h2;
      edges(1);
      chan_slot_tick_in <= 2'h0;
      chk("strobes b", 8'h08, {pcm_strobe_out, sub_strobe_out});
      chk("pcm data b", 8'h3C & ((t == 1) ? 8'hFF : (t < 4) ?
        8'h0F << 4 * (t - 2) : 8'h03 << 2 * (t - 4)), pcm_data_out[1]);
    end
    $display("test channels b ended");
    sig_change_valid_in <= 1'b1;
    changed_slot_addr_in <= 7'h25;
    edges(1);
    sig_change_valid_in <= 1'b0;
    rd(5'h0C, 8'hA5, "signal entry");
    rd(5'h0C, 8'h00, "signal drained");
    acc(5'h0A, 1'b1, 8'h4A);
    chk("cm addr", 8'h14, {1'b0, subscriber_cm_addr_out});
    chk("xfer ctrl", 8'h01, {6'h00, monitor_xfer_ctrl_out});
    rd(5'h0A, 8'h00, "found idle");
    search_start_in <= 1'b1;
    edges(1);
    search_start_in <= 1'b0;
    rd(5'h0A, 8'h40, "searching");
    chk("search flag", 8'h01, {7'h00, srch});
    chan_found_in <= 1'b1;
    chan_found_addr_in <= 6'h15;
    edges(1);
    chan_found_in <= 1'b0;
    rd(5'h0A, 8'h15, "found");
    $display("test signal and monitor address ended");
    mon_rx_dir_in <= 1'b1;
    mon_rx_valid_in <= 1'b1;
    mon_rx_byte_in <= 8'h5A;
    edges(1);
    mon_rx_byte_in <= 8'h96;
    edges(1);
    mon_rx_valid_in <= 1'b0;
    rd(5'h0B, 8'h5A, "rx oldest");
    rd(5'h0B, 8'h96, "rx next");
    mon_rx_dir_in <= 1'b0;
    acc(5'h0B, 1'b1, 8'hC3);
    run <= 1'b1;
    for (int i = 0; i < 300 && nbits != 4'h8; i++) edges(1);
    run <= 1'b0; // following bits are not part of the message
    chk("line byte", 8'hC3, seen);
    $display("test monitor fifo ended");
    acc(5'h0C, 1'b1, 8'h02);
    timer_start_cmd_in <= 1'b1;
    edges(1);
    timer_start_cmd_in <= 1'b0;
    for (int i = 0; i < 200 && timer_expire_out !== 1'b1; i++) edges(1);
    chk("no multiframe", 8'h00, {7'h00, mf_pulse});
    mf <= 3'h7;
    gap = 0;
    do begin
      edges(1);
      gap++;
    end while (timer_expire_out !== 1'b1 && gap < 200);
    chk("timer period", 8'h1E, gap[7:0]);
    chk("multiframe", 8'h01, {7'h00, mf_pulse});
    acc(5'h0C, 1'b1, 8'h02);
    chk("stop on write", 8'h00, {7'h00, timer_active_out});
    timer_start_cmd_in <= 1'b1;
    edges(1);
    timer_start_cmd_in <= 1'b0;
    edges(3);
    chk("restarted", 8'h01, {7'h00, timer_active_out});
    main_operating_bit_in <= 1'b0;
    edges(3);
    chk("stop on main bit", 8'h00, {7'h00, timer_active_out});
    $display("test timer ended");
    close_out();
  end
endmodule
